// ---- src/ack_bus_cycle.sv ----
// chip-select five bus cycle ended by an active-low external acknowledge
`default_nettype none
// Notes on behaviour
// - acknowledge counts as asserted when the pin is low
// - read strobe and byte enables wait the programmed read delay
// - read byte enables assert only while the read inhibit bit is clear
// - read cycle start drives address and asserts chip select together
// - write cycle start drives address and asserts the write strobe
// - internal wait state mode ends the cycle without the acknowledge
// - write select waits select delay, byte enables wait write strobe delay
// - read strobe negates three periods after the acknowledge is seen
// - read strobe negates one period before chip select
// - write strobe negates two periods after the acknowledge is seen
// - write data stays driven two periods after the write strobe negates
// - write data is driven from the first cycle of chip select
// - bus error if no acknowledge within 1022 counts
// - acknowledge termination applies only to chip select five
module ack_bus_cycle (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire ack_bus_pkg::req_t req_in,
  input wire ack_bus_pkg::cfg_t cfg_in,
  input wire logic external_ack_n_in,
  input wire logic [ack_bus_pkg::DATA_W-1:0] rdata_in,
  output ack_bus_pkg::pins_t pins_out,
  output logic done_out,
  output logic bus_error_out,
  output logic [ack_bus_pkg::DATA_W-1:0] rdata_out
);
  typedef struct packed {
    ack_bus_pkg::phase_t phase;
    logic [ack_bus_pkg::CNT_W-1:0] cnt;
    logic [ack_bus_pkg::DLY_W-1:0] dly;
    logic [1:0] tail;
    logic use_ack;
    ack_bus_pkg::req_t req;
    ack_bus_pkg::pins_t pins;
    logic done;
    logic err;
    logic [ack_bus_pkg::DATA_W-1:0] rdata;
    logic [1:0] sync;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic ack_seen;

  // second sync stage only; first stage feeds nothing else
  assign ack_seen = ~s_reg.sync[1];
  assign req_ready_out = (s_reg.phase == ack_bus_pkg::ST_IDLE);
  assign pins_out = s_reg.pins;
  assign done_out = s_reg.done;
  assign bus_error_out = s_reg.err;
  assign rdata_out = s_reg.rdata;

  // cycle sequencer; pins are registered so they never glitch
  always_comb begin
    s_next = s_reg;
    s_next.sync = {s_reg.sync[0], external_ack_n_in};
    s_next.done = 1'b0;
    s_next.err = 1'b0;
    case (s_reg.phase)
      ack_bus_pkg::ST_IDLE: begin
        if (req_valid_in) begin
          s_next.req = req_in;
          // only group five may wait on the pin; others use the wait count
          s_next.use_ack = (req_in.group == ack_bus_pkg::ACK_GROUP) &&
                           !cfg_in.ack_source_select;
          s_next.cnt = '0;
          s_next.pins.addr = req_in.addr;
          if (req_in.write) begin
            s_next.pins.write_n = 1'b0;
            s_next.pins.wdata = req_in.wdata;
            s_next.pins.data_oe = 1'b1;
            s_next.dly = cfg_in.select_assert_delay;
            s_next.pins.chip_select_five_n = (cfg_in.select_assert_delay != '0);
          end else begin
            s_next.dly = cfg_in.read_strobe_delay;
            s_next.pins.chip_select_five_n = 1'b0;
          end
          s_next.phase = ack_bus_pkg::ST_SETUP;
        end
      end
      ack_bus_pkg::ST_SETUP: begin
        // count down the programmed read strobe delay or write select delay
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.dly != '0) begin
          s_next.dly = s_reg.dly - 1'b1;
          // select falls on the last delay step so each count adds one period
          if (s_reg.req.write && s_reg.dly == ack_bus_pkg::DLY_W'(1)) begin
            s_next.pins.chip_select_five_n = 1'b0;
          end
        end else begin
          s_next.pins.chip_select_five_n = 1'b0;
          if (s_reg.req.write) begin
            s_next.dly = cfg_in.write_strobe_delay;
          end else begin
            s_next.pins.output_enable_n = 1'b0;
            if (!cfg_in.byte_enable_read_inhibit) begin
              s_next.pins.byte_enable_n = ~s_reg.req.be;
            end
          end
          s_next.phase = ack_bus_pkg::ST_WAIT;
        end
      end
      ack_bus_pkg::ST_WAIT: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.req.write) begin
          if (s_reg.dly != '0) begin
            s_next.dly = s_reg.dly - 1'b1;
          end else begin
            s_next.pins.byte_enable_n = ~s_reg.req.be;
          end
        end
        if (s_reg.use_ack ? ack_seen
                          : (s_reg.cnt >= ack_bus_pkg::CNT_W'(cfg_in.wait_state_count))) begin
          s_next.tail = s_reg.req.write ? ack_bus_pkg::WRITE_TAIL_CYC
                                        : ack_bus_pkg::READ_TAIL_CYC;
          s_next.phase = ack_bus_pkg::ST_TAIL;
        end else if (s_reg.use_ack && s_reg.cnt >= ack_bus_pkg::TIMEOUT_CYC - 1'b1) begin
          // abort: release every strobe at once
          s_next.err = 1'b1;
          s_next.done = 1'b1;
          s_next.pins.chip_select_five_n = 1'b1;
          s_next.pins.output_enable_n = 1'b1;
          s_next.pins.byte_enable_n = '1;
          s_next.pins.write_n = 1'b1;
          s_next.pins.data_oe = 1'b0;
          s_next.phase = ack_bus_pkg::ST_GAP;
        end
      end
      ack_bus_pkg::ST_TAIL: begin
        // read data is sampled while the strobe is still low
        s_next.tail = s_reg.tail - 1'b1;
        if (s_reg.tail == 2'h1) begin
          if (s_reg.req.write) begin
            s_next.pins.write_n = 1'b1;
            s_next.tail = ack_bus_pkg::DATA_HOLD_CYC;
          end else begin
            s_next.rdata = rdata_in;
            s_next.pins.output_enable_n = 1'b1;
            s_next.pins.byte_enable_n = '1;
            s_next.tail = ack_bus_pkg::SEL_HOLD_CYC;
          end
          s_next.phase = ack_bus_pkg::ST_HOLD;
        end
      end
      ack_bus_pkg::ST_HOLD: begin
        s_next.tail = s_reg.tail - 1'b1;
        s_next.pins.chip_select_five_n = 1'b1;
        s_next.pins.byte_enable_n = '1;
        if (s_reg.tail == 2'h1) begin
          s_next.pins.data_oe = 1'b0;
          s_next.done = 1'b1;
          s_next.phase = ack_bus_pkg::ST_GAP;
        end
      end
      ack_bus_pkg::ST_GAP: begin
        // one idle period between selects
        s_next.phase = ack_bus_pkg::ST_IDLE;
      end
      default: begin
        s_next.phase = ack_bus_pkg::ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_reg <= '0;
      s_reg.phase <= ack_bus_pkg::ST_IDLE;
      s_reg.sync <= 2'h3;
      s_reg.pins.chip_select_five_n <= 1'b1;
      s_reg.pins.output_enable_n <= 1'b1;
      s_reg.pins.byte_enable_n <= '1;
      s_reg.pins.write_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  property p_read_oe_after_ack;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      (s_reg.phase == ack_bus_pkg::ST_WAIT && !s_reg.req.write && s_reg.use_ack && ack_seen)
      |-> ##4 s_reg.pins.output_enable_n;
  endproperty
  // the strobe launched three edges on is first sampled high at the fourth
  a_read_oe_after_ack: assert property (p_read_oe_after_ack) else $error("read oe late");

  property p_write_after_ack;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      (s_reg.phase == ack_bus_pkg::ST_WAIT && s_reg.req.write && s_reg.use_ack && ack_seen)
      |-> !s_reg.pins.write_n ##3 s_reg.pins.write_n;
  endproperty
  a_write_after_ack: assert property (p_write_after_ack) else $error("write strobe late");

  property p_oe_before_cs;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    // a timed-out cycle drops every strobe at once, so it is left out here
      ($rose(s_reg.pins.output_enable_n) && !s_reg.err)
      |-> !s_reg.pins.chip_select_five_n ##1 s_reg.pins.chip_select_five_n;
  endproperty
  a_oe_before_cs: assert property (p_oe_before_cs) else $error("select released early");

  property p_data_hold;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      (s_reg.phase == ack_bus_pkg::ST_HOLD && $rose(s_reg.pins.write_n)) |-> s_reg.pins.data_oe [*2];
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("write data dropped early");

  property p_data_with_cs;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      (!s_reg.pins.chip_select_five_n && !s_reg.pins.write_n) |-> s_reg.pins.data_oe;
  endproperty
  a_data_with_cs: assert property (p_data_with_cs) else $error("write data not driven");

  property p_timeout;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      (s_reg.phase == ack_bus_pkg::ST_WAIT && s_reg.use_ack &&
       s_reg.cnt == ack_bus_pkg::TIMEOUT_CYC - 1'b1 && !ack_seen)
      |=> s_reg.err;
  endproperty
  a_timeout: assert property (p_timeout) else $error("missing bus error");

  property p_read_start;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      (req_valid_in && req_ready_out && !req_in.write)
      |=> !s_reg.pins.chip_select_five_n && s_reg.pins.addr == $past(req_in.addr);
  endproperty
  a_read_start: assert property (p_read_start) else $error("read start wrong");

  property p_write_start;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      (req_valid_in && req_ready_out && req_in.write) |=> !s_reg.pins.write_n;
  endproperty
  a_write_start: assert property (p_write_start) else $error("write strobe not asserted");

  property p_read_inhibit;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
      (!s_reg.req.write && cfg_in.byte_enable_read_inhibit && s_reg.phase == ack_bus_pkg::ST_SETUP)
      |=> s_reg.pins.byte_enable_n == '1;
  endproperty
  a_read_inhibit: assert property (p_read_inhibit) else $error("read byte enable");
endmodule
`default_nettype wire

// ---- src/ack_bus_pkg.sv ----
// package for the acknowledge-terminated chip-select five bus cycle
`default_nettype none
package ack_bus_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int BE_W = 2;
  localparam int DLY_W = 4;
  localparam int WS_W = 6;
  localparam int CNT_W = 11;
  localparam int SEL_W = 3;
  // chip select group that may be ended by the external acknowledge
  localparam logic [SEL_W-1:0] ACK_GROUP = 3'h5;
  // timing counts in system clock periods
  localparam int CLK_HZ = 20000000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  localparam int ACK_LIMIT_T = 1019;
  localparam int TIMEOUT_COUNTS = 1022;
  localparam logic [CNT_W-1:0] TIMEOUT_CYC = CNT_W'(TIMEOUT_COUNTS);
  localparam logic [1:0] READ_TAIL_CYC = 2'h3;
  localparam logic [1:0] WRITE_TAIL_CYC = 2'h2;
  localparam logic [1:0] SEL_HOLD_CYC = 2'h1;
  localparam logic [1:0] DATA_HOLD_CYC = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_WAIT = 3'b010,
    ST_TAIL = 3'b011,
    ST_HOLD = 3'b100,
    ST_GAP = 3'b101
  } phase_t;

  typedef struct packed {
    logic [SEL_W-1:0] group;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0] be;
  } req_t;

  typedef struct packed {
    logic [DLY_W-1:0] read_strobe_delay;
    logic byte_enable_read_inhibit;
    logic [DLY_W-1:0] select_assert_delay;
    logic [DLY_W-1:0] write_strobe_delay;
    logic ack_source_select;
    logic [WS_W-1:0] wait_state_count;
  } cfg_t;

  typedef struct packed {
    logic chip_select_five_n;
    logic output_enable_n;
    logic [BE_W-1:0] byte_enable_n;
    logic write_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic data_oe;
  } pins_t;
endpackage
`default_nettype wire

// ---- tb/ack_periph_model.sv ----
// peripheral on chip-select five that ends each cycle with a low acknowledge
`default_nettype none
module ack_periph_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ack_enable_in,
  input wire logic [7:0] ack_delay_in,
  input wire ack_bus_pkg::pins_t pins_in,
  output logic external_ack_n_out,
  output logic [ack_bus_pkg::DATA_W-1:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] since_cs;
  // a two-cycle low pulse a fixed delay after select, far inside the limit
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      since_cs <= 10'h000;
      external_ack_n_out <= 1'b1;
      rdata_out <= 16'h0000;
    end else begin
      since_cs <= pins_in.chip_select_five_n ? 10'h000 : since_cs + 10'h001;
      external_ack_n_out <= !(ack_enable_in && !pins_in.chip_select_five_n &&
        since_cs >= 10'(ack_delay_in) && since_cs < 10'(ack_delay_in) + 10'h002);
      // toggles when not read so stale data is never mistaken for a valid word
      rdata_out <= !pins_in.output_enable_n ? (pins_in.addr[15:0] ^ 16'h5a5a) :
        ~rdata_out;
    end
  end
endmodule
`default_nettype wire

// ---- tb/external_ack_bus_cycle_bench.sv ----
// self-checking bench for the acknowledge-ended chip-select five cycle
`default_nettype none
module external_ack_bus_cycle_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic req_valid = 1'b0;
  logic ack_on = 1'b0;
  logic ack_n, req_ready, done, berr, err, be_seen;
  logic cs_q = 1'b1, oe_q = 1'b1, wr_q = 1'b1, ack_q = 1'b1;
  logic [15:0] rd_pin, rdata;
  logic [16:0] cs_w;
  logic [23:0] st_addr;
  ack_bus_pkg::req_t req = '0;
  ack_bus_pkg::cfg_t cfg = '0;
  ack_bus_pkg::pins_t pins;
  int failures = 0, total_checks = 0, cyc = 0, n, g0, t_cs, t_oe, t_ack, t_rise, t_doe;
  int t_take, t_be;
  always #25 clk_sys_in = ~clk_sys_in;
  ack_bus_cycle uut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid),
    .req_ready_out(req_ready), .req_in(req), .cfg_in(cfg), .external_ack_n_in(ack_n),
    .rdata_in(rd_pin), .pins_out(pins), .done_out(done), .bus_error_out(berr),
    .rdata_out(rdata));
  ack_periph_model far (.clk_in(clk_sys_in), .rst_b_in(rst_b_in), .ack_enable_in(ack_on),
    .ack_delay_in(8'h05), .pins_in(pins), .external_ack_n_out(ack_n), .rdata_out(rd_pin));
  // edge stamps of pin changes, read before this edge's updates land
  always @(posedge clk_sys_in) begin
    cyc = cyc + 1;
    if (req_valid && req_ready) begin
      be_seen = 1'b0;
      t_take = cyc;
    end
    if (be_seen !== 1'b1 && pins.byte_enable_n !== 2'h3) t_be = cyc;
    if (pins.byte_enable_n !== 2'h3) be_seen = 1'b1;
    if ((cs_q && !pins.chip_select_five_n) || (wr_q && !pins.write_n)) st_addr = pins.addr;
    if (cs_q && !pins.chip_select_five_n) t_cs = cyc;
    if (cs_q && !pins.chip_select_five_n) cs_w = {pins.data_oe, pins.wdata};
    if (oe_q && !pins.output_enable_n) t_oe = cyc;
    if ((!oe_q && pins.output_enable_n) || (!wr_q && pins.write_n)) t_rise = cyc;
    if (ack_q && !ack_n) t_ack = cyc;
    if (pins.data_oe) t_doe = cyc;
    // hang guard: the whole run needs well under this many cycles
    if (cyc > 6000) begin
      failures++;
      stop_test();
    end
    {cs_q, oe_q, wr_q, ack_q} = {pins.chip_select_five_n, pins.output_enable_n, pins.write_n,
      ack_n};
  end
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_rng(input string what, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // one whole cycle; the error pulse lasts one cycle so it is caught beside done
  task automatic run(input logic wr, input logic [2:0] grp, input logic [3:0] dly,
      input logic inh, input logic internal, input logic ack);
    cfg <= '{dly, inh, 4'h2, 4'h1, internal, 6'h04};
    req <= '{grp, wr, 24'h0a0000 + {20'h00000, dly}, 16'hc3a5, 2'h3};
    ack_on <= ack;
    req_valid <= 1'b1;
    @(posedge clk_sys_in iff req_ready === 1'b1);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      #1 n++;
      err = berr;
    end while (done !== 1'b1 && n < 1200);
    check("cycle done", 24'h1, {23'h0, done});
    @(posedge clk_sys_in);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(posedge clk_sys_in);
    run(1'b0, 3'h5, 4'h0, 1'b0, 1'b0, 1'b1);
    g0 = t_oe - t_cs;
    check("read data", 24'h005a5a, {8'h00, rdata});
    check("read error", 24'h0, {23'h0, err});
    check("read address", 24'h0a0000, st_addr);
    check("read byte enable", 24'h1, {23'h0, be_seen});
    check_rng("ack to read strobe", 5, 6, t_rise - t_ack);
    // longer strobe delay with byte enables inhibited
    run(1'b0, 3'h5, 4'h3, 1'b1, 1'b0, 1'b1);
    check_rng("read strobe delay", g0 + 3, g0 + 3, t_oe - t_cs);
    check("inhibited byte enable", 24'h0, {23'h0, be_seen});
    check("read data delayed", 24'h005a59, {8'h00, rdata});
    run(1'b1, 3'h5, 4'h0, 1'b0, 1'b0, 1'b1);
    check("write error", 24'h0, {23'h0, err});
    check("write address", 24'h0a0000, st_addr);
    check("write data at select", 24'h01c3a5, {7'h00, cs_w});
    // select delay of two plus the register stage after the take edge
    check_rng("select delay", 3, 3, t_cs - t_take);
    // strobe delay of one plus the step into the wait phase and the register stage
    check_rng("write byte enable delay", 3, 3, t_be - t_cs);
    check_rng("ack to write strobe", 4, 5, t_rise - t_ack);
    check_rng("write data hold", 1, 3, t_doe - t_rise);
    // silent peripheral: the monitor must end the cycle with an error
    run(1'b0, 3'h5, 4'h0, 1'b0, 1'b0, 1'b0);
    check("timeout error", 24'h1, {23'h0, err});
    check_rng("timeout length", 1022, 1026, n);
    run(1'b0, 3'h5, 4'h0, 1'b0, 1'b1, 1'b0);
    check("internal wait error", 24'h0, {23'h0, err});
    check_rng("internal wait length", 1, 60, n);
    run(1'b0, 3'h3, 4'h0, 1'b0, 1'b0, 1'b0);
    check("other group error", 24'h0, {23'h0, err});
    check_rng("other group length", 1, 60, n);
    stop_test();
  end
endmodule
`default_nettype wire
